// ===== logic/freq_ref_select.v
// Frequency reference selector with Wishbone setup registers
// Function
// R1: Four multi-speed inputs form a code; codes 2-15 pick presets 2-15.
// R2: Jog selection input overrides multi-speed inputs with jog frequency.
// R3: Code zero takes preset 0 on keypad source, analog on terminals.
// R4: Code one takes auxiliary analog when aux setting zero, else preset 1.
// R5: With PID enabled, never switch to auxiliary frequency.
// R6: Forward or reverse jog input runs that direction at jog frequency.
// R7: Jog run outranks every other reference source.
// R8: Jog active over 500 ms causes a stop by the stop mode.
// R9: UP/DOWN act only with terminal run and UP/DOWN source.
// R10: UP/DOWN raise or lower frequency using accel/decel set 1 or 2.
// R11: Config error when only one of UP and DOWN is assigned.
// R12: Config error when UP or DOWN coincides with hold input.
// R13: Forward run with UP or DOWN pulse accelerates to lower limit.
// R14: UP/DOWN frequency stays within upper and lower limits; a retained reference restored on run is checked against lower only.
// R15: Retention on: reference saved, restored, reached on run.
// R16: Retention off: run accelerates to lower limit.
// R17: Hold input freezes output frequency.
// R18: Codes 02-05 are multi-speed 1-4, code 29 is jog selection.
// R19: Inputs are synchronised before selection is evaluated.
//
// The Wishbone register port and the address map were chosen for this implementation.
`include "freq_ref_defines.vh"

module freq_ref_select #(
	parameter W       = 16,
	parameter NDI     = 8,
	parameter JOG_CYC = `JOG_CYCLES
) (
	input  wire           clk_i,
	input  wire           rst_i,
	input  wire [3:0]     wb_adr_i,
	input  wire [31:0]    wb_dat_i,
	input  wire [3:0]     wb_sel_i,
	input  wire           wb_we_i,
	input  wire           wb_cyc_i,
	input  wire           wb_stb_i,
	output reg  [31:0]    wb_dat_o,
	output reg            wb_ack_o,
	input  wire [NDI-1:0] di_i,
	input  wire [NDI*7-1:0] di_func_i,
	input  wire           run_fwd_i,
	input  wire           run_rev_i,
	input  wire [W-1:0]   analog_input_one_i,
	input  wire [W-1:0]   analog_input_two_i,
	input  wire [W*16-1:0] preset_i,
	input  wire [W-1:0]   stored_ref_i,
	input  wire           power_fail_i,
	output reg  [W-1:0]   save_ref_o,
	output reg            save_strobe_o,
	output wire [W-1:0]   freq_o,
	output reg            dir_rev_o,
	output reg            running_o,
	output reg            jog_stop_o,
	output reg            input_config_error_o
);
	// Setup registers; ctrl, limits and jog are bus-writable, rate_q keeps its reset value
	reg [31:0] ctrl_q;
	reg [31:0] limits_q;
	reg [31:0] jog_q;
	reg [31:0] rate_q;

	wire [1:0] fsrc   = ctrl_q[`CTRL_FSRC_LO+1:`CTRL_FSRC_LO];
	wire [1:0] rsrc   = ctrl_q[`CTRL_RSRC_LO+1:`CTRL_RSRC_LO];
	wire [2:0] aux    = ctrl_q[`CTRL_AUX_LO+2:`CTRL_AUX_LO];
	wire       pid_en = ctrl_q[`CTRL_PID_BIT];
	wire       retain = ctrl_q[`CTRL_RET_BIT];
	wire       set2   = ctrl_q[`CTRL_ACC2_BIT];
	wire [W-1:0] upper = limits_q[31:16];
	wire [W-1:0] lower = limits_q[15:0];
	wire [W-1:0] jog_f = jog_q[15:0];

	// Two-stage input synchroniser; only stage two is decoded
	reg [NDI-1:0] s1_q;
	reg [NDI-1:0] s2_q;
	always @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= {NDI{1'b0}};
			s2_q <= {NDI{1'b0}};
		end else begin
			s1_q <= di_i;
			s2_q <= s1_q; // R19
		end
	end

	// Decode each terminal's assigned function
	wire [NDI-1:0] m1, m2, m3, m4, mj, mf, mr, mu, md, mh, mp;
	wire [NDI-1:0] au, ad;
	genvar g;
	generate
		for (g = 0; g < NDI; g = g + 1) begin : dec
			wire [6:0] f = di_func_i[g*7+6:g*7];
			assign m1[g] = s2_q[g] && f == `FN_MS1; // R18
			assign m2[g] = s2_q[g] && f == `FN_MS2;
			assign m3[g] = s2_q[g] && f == `FN_MS3;
			assign m4[g] = s2_q[g] && f == `FN_MS4;
			assign mj[g] = s2_q[g] && f == `FN_JOG_SEL;
			assign mf[g] = s2_q[g] && f == `FN_FWD_JOG;
			assign mr[g] = s2_q[g] && f == `FN_REV_JOG;
			assign mu[g] = s2_q[g] && f == `FN_UP;
			assign md[g] = s2_q[g] && f == `FN_DOWN;
			assign mh[g] = s2_q[g] && f == `FN_HOLD;
			assign mp[g] = s2_q[g] && f == `FN_PID_OFF;
			assign au[g] = f == `FN_UP;
			assign ad[g] = f == `FN_DOWN;
		end
	endgenerate

	wire [3:0] code = {|m4, |m3, |m2, |m1}; // R1
	wire jog_sel  = |mj;
	wire jog_run  = |mf | |mr;
	wire up_in    = |mu;
	wire dn_in    = |md;
	wire hold_in  = |mh;
	wire run_cmd  = run_fwd_i | run_rev_i | jog_run;
	wire ud_mode  = (rsrc == `RUN_TERMINALS) && (fsrc == `SRC_UPDOWN); // R9

	// Multi-speed selection; the PID-disable input cannot reach aux
	reg [W-1:0] ms_ref;
	always @* begin
		case (code)
			4'h0: ms_ref = (fsrc == `SRC_TERMINAL) ? analog_input_one_i
				: preset_i[W-1:0]; // R3
			4'h1: ms_ref = (aux == `AUX_ANALOG && !pid_en) ?
				analog_input_two_i : preset_i[2*W-1:W]; // R4 R5
			default: ms_ref = preset_i[code*W +: W]; // R1
		endcase
	end

	// UP/DOWN reference held between steps; steps clamped to limits, restored value checked against lower only
	reg [W-1:0] ud_q;
	reg         run_q;
	reg [W-1:0] step;
	always @* begin
		step = set2 ? rate_q[31:16] : rate_q[15:0]; // R10
	end
	always @(posedge clk_i) begin
		if (rst_i) begin
			ud_q  <= {W{1'b0}};
			run_q <= 1'b0;
		end else begin
			run_q <= run_cmd;
			if (run_cmd && !run_q) begin
				ud_q <= (retain && stored_ref_i > lower) ?
					stored_ref_i : lower; // R15 R16
			end else if (ud_mode && run_cmd && !hold_in
				&& freq_o >= lower) begin // R13
				if (up_in && !dn_in) begin
					ud_q <= (ud_q > upper - step) ? upper
						: ud_q + step; // R14
				end else if (dn_in && !up_in) begin
					ud_q <= (ud_q < lower + step) ? lower
						: ud_q - step; // R14
				end else if (ud_q < lower) begin
					ud_q <= lower; // R13
				end
			end
		end
	end

	// Jog outranks every other reference source; stop and jog timeout force zero first; selection used when running
	reg [W-1:0] target;
	always @* begin
		if (!run_cmd || jog_stop_o)
			target = {W{1'b0}};
		else if (jog_run || jog_sel)
			target = jog_f; // R2 R6 R7
		else if (ud_mode)
			target = ud_q;
		else
			target = ms_ref;
	end

	ramp_step #(.W(W)) ramp (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.target_i (target),
		.rate_i   (step),
		.hold_i   (hold_in),
		.freq_o   (freq_o)
	);

	// Jog duration counter; long jogs stop the drive
	reg [31:0] jog_cnt_q;
	always @(posedge clk_i) begin
		if (rst_i) begin
			jog_cnt_q  <= 32'h0;
			jog_stop_o <= 1'b0;
		end else if (!jog_run) begin
			jog_cnt_q  <= 32'h0;
			jog_stop_o <= 1'b0;
		end else if (jog_cnt_q < JOG_CYC) begin
			jog_cnt_q <= jog_cnt_q + 32'h1;
		end else begin
			jog_stop_o <= 1'b1; // R8
		end
	end

	// Status outputs, error and retention save
	always @(posedge clk_i) begin
		if (rst_i) begin
			dir_rev_o            <= 1'b0;
			running_o            <= 1'b0;
			input_config_error_o <= 1'b0;
			save_ref_o           <= {W{1'b0}};
			save_strobe_o        <= 1'b0;
		end else begin
			dir_rev_o <= (|mr) | (run_rev_i & ~jog_run); // R6
			running_o <= run_cmd & ~jog_stop_o;
			input_config_error_o <= ((|au) ^ (|ad)) | // R11
				((up_in | dn_in) & hold_in); // R12
			save_strobe_o <= power_fail_i & retain; // R15
			if (power_fail_i && retain)
				save_ref_o <= freq_o;
		end
	end

	// Wishbone classic slave: ack one cycle after request
	integer b;
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			ctrl_q   <= 32'h0;
			limits_q <= 32'h0;
			jog_q    <= 32'h0;
			rate_q   <= 32'h00010001;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				case (wb_adr_i)
					`REG_CTRL:   wb_dat_o <= ctrl_q;
					`REG_LIMITS: wb_dat_o <= limits_q;
					`REG_JOG:    wb_dat_o <= jog_q;
					`REG_STATUS: wb_dat_o <= {12'h0,
						input_config_error_o, jog_stop_o,
						running_o, dir_rev_o, freq_o};
					default:     wb_dat_o <= 32'h0;
				endcase
				if (wb_we_i) begin
					for (b = 0; b < 4; b = b + 1) begin
						if (wb_sel_i[b]) begin
							case (wb_adr_i)
								`REG_CTRL:
									ctrl_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
								`REG_LIMITS:
									limits_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
								`REG_JOG:
									jog_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
								default:
									rate_q <= rate_q;
							endcase
						end
					end
				end
			end
		end
	end
endmodule // freq_ref_select

// ===== include/freq_ref_defines.vh
// Constants for the drive frequency reference selector
`ifndef FREQ_REF_DEFINES_VH
`define FREQ_REF_DEFINES_VH

// Input function codes assigned to digital input terminals
`define FN_FWD_JOG      7'h06
`define FN_REV_JOG      7'h07
`define FN_UP           7'h08
`define FN_DOWN         7'h09
`define FN_HOLD         7'h0B
`define FN_MS1          7'h02
`define FN_MS2          7'h03
`define FN_MS3          7'h04
`define FN_MS4          7'h05
`define FN_PID_OFF      7'h10
`define FN_JOG_SEL      7'h1D

// Setting values
`define SRC_KEYPAD      2'h0
`define SRC_TERMINAL    2'h1
`define SRC_UPDOWN      2'h2
`define RUN_TERMINALS   2'h1
`define AUX_ANALOG      3'h0

// Wishbone register byte offsets
`define REG_CTRL        4'h0
`define REG_LIMITS      4'h4
`define REG_JOG         4'h8
`define REG_STATUS      4'hC

// Field positions in the control register
`define CTRL_FSRC_LO    0
`define CTRL_RSRC_LO    2
`define CTRL_AUX_LO     4
`define CTRL_PID_BIT    7
`define CTRL_RET_BIT    8
`define CTRL_ACC2_BIT   9

// Jog timeout: 500 ms at 20 MHz
`define JOG_LIMIT_MS    500
`define CLK_KHZ         20000
`define JOG_CYCLES      (`JOG_LIMIT_MS * `CLK_KHZ)

`endif

// ===== logic/ramp_step.v
// Output frequency ramp stepping toward a target at a set rate, with hold
`include "freq_ref_defines.vh"

module ramp_step #(
	parameter W = 16
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire [W-1:0] target_i,
	input  wire [W-1:0] rate_i,
	input  wire         hold_i,
	output reg  [W-1:0] freq_o
);
	reg [W:0] sum;
	reg [W-1:0] diff;

	// Step size never overshoots the target
	always @* begin
		diff = (target_i > freq_o) ? (target_i - freq_o)
			: (freq_o - target_i);
		sum  = {1'b0, freq_o} + {1'b0, (rate_i < diff) ? rate_i : diff};
	end

	// Hold freezes the output where it stands
	always @(posedge clk_i) begin
		if (rst_i) begin
			freq_o <= {W{1'b0}};
		end else if (hold_i) begin
			freq_o <= freq_o; // R17
		end else if (target_i > freq_o) begin
			freq_o <= sum[W-1:0];
		end else begin
			freq_o <= freq_o - ((rate_i < diff) ? rate_i : diff);
		end
	end
endmodule // ramp_step

// ===== test/freq_ref_select_sva.sv
// Port checks for the frequency reference selector
`include "freq_ref_defines.vh"
module freq_ref_select_sva #(
	parameter W       = 16,
	parameter NDI     = 8,
	parameter JOG_CYC = 20
) (
	input logic             clk_i,
	input logic             rst_i,
	input logic             wb_cyc_i,
	input logic             wb_stb_i,
	input logic             wb_ack_o,
	input logic [NDI-1:0]   di_i,
	input logic [NDI*7-1:0] di_func_i,
	input logic             power_fail_i,
	input logic             save_strobe_o,
	input logic [W-1:0]     freq_o,
	input logic             dir_rev_o,
	input logic             jog_stop_o,
	input logic             input_config_error_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hold_raw, up_raw, rev_raw, fwd_raw;
	int   jog_cnt;
	// Raw terminal decode, ahead of the design's synchronisers
	always_comb begin
		{hold_raw, up_raw, rev_raw, fwd_raw} = 4'h0;
		for (int g = 0; g < NDI; g++)
			if (di_i[g]) case (di_func_i[g*7+:7])
			`FN_HOLD: hold_raw = 1'b1;
			`FN_UP, `FN_DOWN: up_raw = 1'b1;
			`FN_REV_JOG: rev_raw = 1'b1;
			`FN_FWD_JOG: fwd_raw = 1'b1;
			default: ;
			endcase
	end
	// Jog press length; saturates so it never wraps
	always_ff @(posedge clk_i)
		if (rst_i || !(fwd_raw || rev_raw)) jog_cnt <= 0;
		else if (jog_cnt < JOG_CYC + 8) jog_cnt <= jog_cnt + 1;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_follows: assert property (
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("ack missing");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	chk_reset_clear: assert property (disable iff (1'b0)
		rst_i |=> (freq_o == '0 && !wb_ack_o && !jog_stop_o))
		else $error("outputs live in reset");
	chk_save_cause: assert property (
		save_strobe_o |-> $past(power_fail_i))
		else $error("save without power loss");
	chk_hold_freeze: assert property (
		hold_raw [*4] |=> $stable(freq_o))
		else $error("freq moved under hold");
	chk_hold_clash: assert property (
		(up_raw && hold_raw) [*4] |=> input_config_error_o)
		else $error("clash not flagged");
	chk_rev_dir: assert property (
		(rev_raw && !fwd_raw && !jog_stop_o) [*4] |=> dir_rev_o)
		else $error("reverse jog not reverse");
	chk_jog_limit: assert property (
		jog_cnt == JOG_CYC + 8 |-> jog_stop_o)
		else $error("long jog not stopped");
	cover property (wb_ack_o);
	cover property (jog_stop_o);
	cover property (input_config_error_o);
endmodule // freq_ref_select_sva
bind freq_ref_select freq_ref_select_sva #(.W(W), .NDI(NDI),
	.JOG_CYC(JOG_CYC)) i_sva (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.di_i(di_i), .di_func_i(di_func_i), .power_fail_i(power_fail_i),
	.save_strobe_o(save_strobe_o), .freq_o(freq_o),
	.dir_rev_o(dir_rev_o), .jog_stop_o(jog_stop_o),
	.input_config_error_o(input_config_error_o));

// ===== test/di_ctrl_model.sv
// Terminal controller model: ten wired inputs
`include "freq_ref_defines.vh"
module di_ctrl_model (
	input  logic        clk_i,
	input  logic [9:0]  want_i,
	input  logic        down_fn_i,
	output logic [9:0]  di_o,
	output logic [69:0] func_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// One terminal per function; down may be unassigned
	assign func_o = {`FN_HOLD, down_fn_i ? `FN_DOWN : 7'h7F, `FN_UP,
		`FN_REV_JOG, `FN_FWD_JOG, `FN_JOG_SEL, `FN_MS4, `FN_MS3,
		`FN_MS2, `FN_MS1};
	// Levels move just after an edge
	always_ff @(posedge clk_i)
		di_o <= want_i;
endmodule // di_ctrl_model

// ===== test/freq_ref_select_tb.sv
// Bench for the frequency reference selector
`include "freq_ref_defines.vh"
module freq_ref_select_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int JC = 20;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic run_fwd = 0, pf = 0, dn_fn = 1;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] dat = 32'h0, rdat, q;
	logic [9:0] want = 10'h000, di;
	logic [69:0] fn;
	logic [255:0] pre;
	logic [15:0] freq, sref;
	logic ack, dir_rev, jstop, err, sstb, runo;
	int failures = 0, comparisons = 0;
	// 20 MHz clock
	always #25 clk_i = ~clk_i;
	di_ctrl_model i_ctl (.clk_i(clk_i), .want_i(want),
		.down_fn_i(dn_fn), .di_o(di), .func_o(fn));
	freq_ref_select #(.NDI(10), .JOG_CYC(JC)) i_dut (.clk_i(clk_i),
		.rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
		.wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
		.wb_ack_o(ack), .di_i(di), .di_func_i(fn), .run_fwd_i(run_fwd),
		.run_rev_i(1'b0), .analog_input_one_i(16'h0050),
		.analog_input_two_i(16'h0060), .preset_i(pre),
		.stored_ref_i(16'h0030), .power_fail_i(pf), .save_ref_o(sref),
		.save_strobe_o(sstb), .freq_o(freq), .dir_rev_o(dir_rev),
		.running_o(runo), .jog_stop_o(jstop), .input_config_error_o(err));
	task automatic chk(input string nm, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// One classic cycle; held until ack is sampled
	task automatic bus(input logic [3:0] a, input logic w,
		input logic [31:0] d);
		int n;
		@(posedge clk_i);
		{adr, we, dat, sel} <= {a, w, d, 4'hF};
		{cyc, stb} <= 2'h3;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		{cyc, stb} <= 2'h0;
		if (ack !== 1'b1) begin
			chk("ack", 32'h1, 32'(ack));
			final_report();
		end
	endtask
	task automatic wf(input logic [15:0] e);
		for (int n = 0; n < 400 && freq !== e; n++)
			@(posedge clk_i);
		chk("freq", 32'(e), 32'(freq));
		if (freq !== e)
			final_report();
	endtask
	task automatic pick(input logic [31:0] c, input logic [3:0] k,
		input logic [15:0] e);
		bus(`REG_CTRL, 1'b1, c);
		want[3:0] <= k;
		wf(e);
	endtask
	task automatic t_regs;
		bus(`REG_JOG, 1'b1, 32'h0000_0030);
		bus(`REG_JOG, 1'b0, 32'h0);
		chk("jog reg", 32'h0000_0030, q);
		bus(4'h2, 1'b0, 32'h0);
		chk("unmapped", 32'h0, q);
		bus(`REG_STATUS, 1'b1, 32'hFFFF_FFFF);
		bus(`REG_STATUS, 1'b0, 32'h0);
		chk("status", 32'h0, q);
		$display("regs done");
	endtask
	task automatic t_speed;
		run_fwd <= 1'b1;
		for (int k = 15; k > 1; k--)
			pick(32'h0, k[3:0], 16'(k * 8 + 8));
		want[9] <= 1'b1;
		repeat (4) @(posedge clk_i);
		want[3:0] <= 4'hF;
		repeat (20) @(posedge clk_i);
		chk("hold", 32'h0018, 32'(freq));
		want[9] <= 1'b0;
		pick(32'h0, 4'h1, 16'h0060);
		pick(32'h80, 4'h1, 16'h0010);
		pick(32'h0, 4'h1, 16'h0060);
		pick(32'h10, 4'h1, 16'h0010);
		pick(32'h1, 4'h0, 16'h0050);
		pick(32'h0, 4'h0, 16'h0008);
		want[4] <= 1'b1;
		pick(32'h0, 4'hF, 16'h0030);
		$display("speed done");
	endtask
	task automatic t_jog;
		// Selection input dropped so only the jog run holds 0x30
		want[5:4] <= 2'h2;
		repeat (6) @(posedge clk_i);
		chk("jog freq", 32'h0030, 32'(freq));
		chk("running", 32'h1, 32'(runo));
		repeat (JC + 4) @(posedge clk_i);
		chk("jog stop", 32'h1, 32'(jstop));
		chk("stopped", 32'h0, 32'(runo));
		want[5] <= 1'b0;
		repeat (4) @(posedge clk_i);
		want[6] <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk("reverse", 32'h1, 32'(dir_rev));
		want[6:4] <= 3'h0;
		$display("jog done");
	endtask
	task automatic t_updown;
		bus(`REG_LIMITS, 1'b1, 32'h0040_0010);
		run_fwd <= 1'b0;
		bus(`REG_CTRL, 1'b1, 32'h6);
		// Start from standstill so the pulse meets a stopped motor
		wf(16'h0000);
		run_fwd <= 1'b1;
		want[7] <= 1'b1;
		@(posedge clk_i);
		want[7] <= 1'b0;
		wf(16'h0010);
		want[7] <= 1'b1;
		wf(16'h0040);
		repeat (10) @(posedge clk_i);
		chk("upper", 32'h0040, 32'(freq));
		bus(`REG_CTRL, 1'b1, 32'h206);
		want[8:7] <= 2'h2;
		wf(16'h0010);
		repeat (10) @(posedge clk_i);
		chk("lower", 32'h0010, 32'(freq));
		want[8] <= 1'b0;
		dn_fn <= 1'b0;
		repeat (5) @(posedge clk_i);
		chk("one assigned", 32'h1, 32'(err));
		dn_fn <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk("both assigned", 32'h0, 32'(err));
		bus(`REG_CTRL, 1'b1, 32'h106);
		pf <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("save", 32'h1_0010, {15'h0, sstb, sref});
		pf <= 1'b0;
		run_fwd <= 1'b0;
		repeat (20) @(posedge clk_i);
		run_fwd <= 1'b1;
		wf(16'h0030);
		want[9:7] <= 3'h5;
		repeat (5) @(posedge clk_i);
		chk("clash", 32'h1, 32'(err));
		want <= 10'h000;
		$display("updown done");
	endtask
	// Reset, then the scenarios in turn
	initial begin
		for (int k = 0; k < 16; k++)
			pre[k*16+:16] = 16'(k * 8 + 8);
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_speed();
		t_jog();
		t_updown();
		final_report();
	end
endmodule // freq_ref_select_tb
